/* core/bridge_pkg.sv */
// Purpose: constants and types for the serial bus command bridge
// Assumes: 25 MHz clock, one command handled at a time
// Notes on behaviour
// R1: host sends every command over the control endpoint only.
// R2: command arrives as class request 0x21/0x09, index 3, bytes in data stage.
// R3: byte 0 is operation ORed with interface; read 0x00, write 0x10.
// R4: interface codes: 0x08 pins, 0x04 spi16, 0x02 fast, 0x01 standard, 0x00 spi8.
// R5: byte 1 is two-wire target address or spi16 upper address byte.
// R6: byte 2 is the number of data bytes moved.
// R7: byte 3 is register address, or spi16 low address byte.
// R8: write data from byte 4; at most 60 bytes, packet 64 bytes.
// R9: reply is capped at 42 bytes; host keeps commands near 32 bytes. The code sends replies of up to 64 bytes.
// R10: every command is answered with a reply packet.
// R11: reply byte 0 is byte 0 ORed with 0x80, 0x40 or 0x20 status.
// R12: clean transaction returns byte 0 with only 0x20 added.
// R13: failed serial transfer, such as missing acknowledge, sets 0x40.
// R14: undefined byte 0 value is rejected with 0x80 set.
// R15: reply bytes 1 and 3 echo header on two-wire, capture input on spi. On spi8 the code echoes byte 1 and captures byte 3 only.
// R16: reply byte 2 repeats length; then written data echo or read data.
// R17: read command sends header only; read data returns from byte 4.
// R18: pin interface ignores addresses, length one, bits 6..0 map seven pins.
// R19: one command at a time; reply after transfer, before next command.
package bridge_pkg;
    localparam int CLOCK_NS = 40;
    localparam int STD_QUARTER_NS = 2500;
    localparam int FAST_QUARTER_NS = 625;
    localparam logic [5:0] STD_QUARTER_CYC = 6'((STD_QUARTER_NS + CLOCK_NS - 1) / CLOCK_NS);
    localparam logic [5:0] FAST_QUARTER_CYC = 6'((FAST_QUARTER_NS + CLOCK_NS - 1) / CLOCK_NS);

    localparam logic [7:0] SETUP_REQ_TYPE = 8'h21;
    localparam logic [7:0] SETUP_REQ_CODE = 8'h09;
    localparam logic [15:0] SETUP_INDEX = 16'h0003;

    localparam logic [3:0] SPI_BYTE_ADDR_SELECT = 4'h0;
    localparam logic [3:0] STANDARD_TWO_WIRE_SELECT = 4'h1;
    localparam logic [3:0] FAST_TWO_WIRE_SELECT = 4'h2;
    localparam logic [3:0] SPI_WORD_ADDR_SELECT = 4'h4;
    localparam logic [3:0] GPIO_SELECT = 4'h8;
    localparam int WRITE_BIT = 4;

    localparam logic [7:0] REQUEST_ERROR_FLAG = 8'h80;
    localparam logic [7:0] BUS_FAILURE_FLAG = 8'h40;
    localparam logic [7:0] REQUEST_DONE_FLAG = 8'h20;

    localparam logic [6:0] HDR_BYTES = 7'h04;
    localparam logic [7:0] MAX_DATA = 8'h3C;
    localparam logic [6:0] PACKET_BYTES = 7'h40;

    typedef enum logic [3:0] {
        OP_START = 4'b0001,
        OP_STOP = 4'b0010,
        OP_I2C = 4'b0100,
        OP_SPI = 4'b1000
    } op_e;

    typedef enum logic [1:0] {
        ES_IDLE = 2'b01,
        ES_RUN = 2'b10
    } eng_e;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_RECV = 6'b000010,
        ST_DECODE = 6'b000100,
        ST_EXEC = 6'b001000,
        ST_WAIT = 6'b010000,
        ST_REPLY = 6'b100000
    } state_e;

    typedef enum logic [7:0] {
        PH_START = 8'b00000001,
        PH_ADDR = 8'b00000010,
        PH_REG = 8'b00000100,
        PH_DATA = 8'b00001000,
        PH_RSTART = 8'b00010000,
        PH_RADDR = 8'b00100000,
        PH_RDATA = 8'b01000000,
        PH_STOP = 8'b10000000
    } phase_e;

    typedef struct packed {
        logic valid;
        logic [7:0] req_type;
        logic [7:0] req_code;
        logic [15:0] index;
    } setup_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } byte_s;
endpackage

/* core/serial_byte_engine.sv */
// Purpose: bit level engine for two-wire start, stop, byte and spi byte exchange
// Assumes: each bit takes four quarter periods; no clock stretching by targets
// Notes: two-wire lines are open drain, released unless pulled low
`timescale 1ns/1ps
module serial_byte_engine (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_start,
    input wire bridge_pkg::op_e i_op,
    input wire logic i_fast,
    input wire logic [7:0] i_tx,
    input wire logic i_ack_send,
    input wire logic i_sda,
    input wire logic i_miso,
    output logic o_done,
    output logic [7:0] o_rx,
    output logic o_nack,
    output logic o_scl_oe,
    output logic o_sda_oe,
    output logic o_sclk,
    output logic o_mosi
);
    bridge_pkg::eng_e st_r;
    bridge_pkg::op_e op_r;
    logic [5:0] cnt_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [8:0] sh_r;
    logic [8:0] rx_r;
    logic scl_low_r, sda_low_r, sclk_r, mosi_r, done_r, fast_r;
    wire [5:0] lim = fast_r ? bridge_pkg::FAST_QUARTER_CYC - 6'h01 : bridge_pkg::STD_QUARTER_CYC - 6'h01;
    wire tick = (cnt_r == lim);
    wire is_spi = (op_r == bridge_pkg::OP_SPI);
    wire is_frame = (op_r == bridge_pkg::OP_START) || (op_r == bridge_pkg::OP_STOP);
    wire last_bit = is_spi ? (bit_r == 4'h7) : (bit_r == 4'h8);

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= bridge_pkg::ES_IDLE;
            op_r <= bridge_pkg::OP_STOP;
            cnt_r <= 6'h00;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 9'h000;
            rx_r <= 9'h000;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            sclk_r <= 1'b0;
            mosi_r <= 1'b0;
            done_r <= 1'b0;
            fast_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (st_r)
                bridge_pkg::ES_IDLE: begin
                    if (i_start) begin
                        st_r <= bridge_pkg::ES_RUN;
                        op_r <= i_op;
                        fast_r <= i_fast;
                        cnt_r <= 6'h00;
                        q_r <= 2'h0;
                        bit_r <= 4'h0;
                        rx_r <= 9'h000;
                        sh_r <= {i_tx, i_ack_send};
                        if (i_op == bridge_pkg::OP_SPI) begin
                            mosi_r <= i_tx[7];
                        end else if (i_op == bridge_pkg::OP_I2C) begin
                            sda_low_r <= ~i_tx[7];
                        end else begin
                            sda_low_r <= (i_op == bridge_pkg::OP_STOP);
                        end
                    end
                end
                bridge_pkg::ES_RUN: begin
                    cnt_r <= tick ? 6'h00 : cnt_r + 6'h01;
                    if (tick) begin
                        q_r <= q_r + 2'h1;
                        if (q_r == 2'h0) begin
                            if (is_spi) sclk_r <= 1'b1;
                            else scl_low_r <= 1'b0;
                        end
                        // R15: capture while clock high
                        if (q_r == 2'h1) begin
                            if (op_r == bridge_pkg::OP_START) sda_low_r <= 1'b1;
                            else if (op_r == bridge_pkg::OP_STOP) sda_low_r <= 1'b0;
                            else rx_r <= {rx_r[7:0], is_spi ? i_miso : i_sda};
                        end
                        if (q_r == 2'h2) begin
                            if (is_spi) sclk_r <= 1'b0;
                            else if (op_r != bridge_pkg::OP_STOP) scl_low_r <= 1'b1;
                        end
                        if (q_r == 2'h3) begin
                            if (is_frame || last_bit) begin
                                st_r <= bridge_pkg::ES_IDLE;
                                done_r <= 1'b1;
                            end else begin
                                bit_r <= bit_r + 4'h1;
                                sh_r <= {sh_r[7:0], 1'b1};
                                if (is_spi) mosi_r <= sh_r[7];
                                else sda_low_r <= ~sh_r[7];
                            end
                        end
                    end
                end
                default: st_r <= bridge_pkg::ES_IDLE;
            endcase
        end
    end

    assign o_done = done_r;
    assign o_rx = is_spi ? rx_r[7:0] : rx_r[8:1];
    // R13: acknowledge bit sampled high means no answer
    assign o_nack = rx_r[0];
    assign o_scl_oe = scl_low_r;
    assign o_sda_oe = sda_low_r;
    assign o_sclk = sclk_r;
    assign o_mosi = mosi_r;
endmodule // serial_byte_engine

/* core/usb_serial_bus_command_bridge.sv */
// Purpose: decodes command packets and runs two-wire, spi or pin transactions
// Assumes: setup and data stage already unpacked by the endpoint logic
// Notes: reply streams out with valid/ready; command packets over 64 bytes lose the tail
`timescale 1ns/1ps
module usb_serial_bus_command_bridge (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire bridge_pkg::setup_s i_setup,
    input wire bridge_pkg::byte_s i_cmd,
    output logic o_cmd_ready,
    output bridge_pkg::byte_s o_rsp,
    input wire logic i_rsp_ready,
    input wire logic i_sda,
    output logic o_scl_oe,
    output logic o_scl_out,
    output logic o_sda_oe,
    output logic o_sda_out,
    output logic o_sclk,
    output logic o_mosi,
    input wire logic i_miso,
    output logic o_spi_cs_n,
    output logic [6:0] o_gpio,
    input wire logic [6:0] i_gpio
);
    bridge_pkg::state_e st_r;
    bridge_pkg::phase_e ph_r;
    bridge_pkg::byte_s rsp_r;
    logic [7:0] pkt_r [0:63];
    logic [6:0] count_r, total_r;
    logic [5:0] di_r, ridx_r;
    logic [7:0] stat_r;
    logic fail_r, cs_n_r, rdy_r, eng_start_r;
    logic [6:0] gpio_r;
    logic eng_done, eng_nack;
    logic [7:0] eng_rx;

    function automatic logic [5:0] data_slot(input logic [5:0] idx);
        data_slot = 6'(idx + 6'h04);
    endfunction

    // R2: only a matching class request opens the data stage
    wire setup_hit = i_setup.valid && (i_setup.req_type == bridge_pkg::SETUP_REQ_TYPE)
        && (i_setup.req_code == bridge_pkg::SETUP_REQ_CODE) && (i_setup.index == bridge_pkg::SETUP_INDEX);
    // R3: operation ored with interface
    wire [7:0] hdr = pkt_r[0];
    wire [3:0] iface = hdr[3:0];
    wire is_wr = hdr[bridge_pkg::WRITE_BIT];
    // R4: interface selection
    wire is_i2c = (iface == bridge_pkg::STANDARD_TWO_WIRE_SELECT) || (iface == bridge_pkg::FAST_TWO_WIRE_SELECT);
    wire is_gpio = (iface == bridge_pkg::GPIO_SELECT);
    wire is_spi = (iface == bridge_pkg::SPI_BYTE_ADDR_SELECT) || (iface == bridge_pkg::SPI_WORD_ADDR_SELECT);
    // R14: any other byte 0 value is undefined
    wire hdr_ok = (hdr[7:5] == 3'h0) && (is_i2c || is_gpio || is_spi);
    // R18: pin transfers always move one byte
    wire [7:0] len = is_gpio ? 8'h01 : pkt_r[2];
    // R6: length sets data count
    wire [6:0] need = bridge_pkg::HDR_BYTES + (is_wr ? len[6:0] : 7'h00);
    // R8: length above 60 or short write packet is a malformed request
    wire req_err = !hdr_ok || (len > bridge_pkg::MAX_DATA) || (count_r < need);
    wire last_data = ({2'h0, di_r} == len - 8'h01);
    wire [7:0] slot_byte = pkt_r[data_slot(di_r)];
    wire rd_phase = (ph_r == bridge_pkg::PH_RDATA);
    wire addr_phase = (ph_r == bridge_pkg::PH_ADDR) || (ph_r == bridge_pkg::PH_RADDR);
    // R5 R7: address bytes sent
    wire [7:0] eng_tx = (ph_r == bridge_pkg::PH_ADDR) ? (is_spi ? pkt_r[1] : {pkt_r[1][7:1], 1'b0})
        : (ph_r == bridge_pkg::PH_REG) ? pkt_r[3]
        : (ph_r == bridge_pkg::PH_RADDR) ? {pkt_r[1][7:1], 1'b1}
        : (ph_r == bridge_pkg::PH_DATA && is_wr) ? slot_byte
        : rd_phase ? 8'hFF : 8'h00;
    wire eng_ack = rd_phase ? last_data : 1'b1;
    wire bridge_pkg::op_e eng_op = (ph_r == bridge_pkg::PH_START || ph_r == bridge_pkg::PH_RSTART)
        ? bridge_pkg::OP_START : (ph_r == bridge_pkg::PH_STOP) ? bridge_pkg::OP_STOP
        : is_spi ? bridge_pkg::OP_SPI : bridge_pkg::OP_I2C;
    wire nack_hit = is_i2c && eng_nack && (addr_phase || ph_r == bridge_pkg::PH_REG
        || (ph_r == bridge_pkg::PH_DATA && is_wr));
    // R11: status ORed into the echoed byte 0
    wire [7:0] rsp_byte = (ridx_r == 6'h00) ? (hdr | stat_r) : pkt_r[ridx_r];
    wire rsp_last = ({1'b0, ridx_r} == total_r - 7'h01);

    serial_byte_engine u_engine (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_start(eng_start_r),
        .i_op(eng_op),
        .i_fast(iface != bridge_pkg::STANDARD_TWO_WIRE_SELECT),
        .i_tx(eng_tx),
        .i_ack_send(eng_ack),
        .i_sda(i_sda),
        .i_miso(i_miso),
        .o_done(eng_done),
        .o_rx(eng_rx),
        .o_nack(eng_nack),
        .o_scl_oe(o_scl_oe),
        .o_sda_oe(o_sda_oe),
        .o_sclk(o_sclk),
        .o_mosi(o_mosi)
    );

    always_ff @(posedge i_clock) begin
        if (st_r == bridge_pkg::ST_RECV && i_cmd.valid && count_r < bridge_pkg::PACKET_BYTES) begin
            pkt_r[count_r[5:0]] <= i_cmd.data;
        end else if (st_r == bridge_pkg::ST_DECODE && !req_err && is_gpio && !is_wr) begin
            pkt_r[4] <= {1'b0, i_gpio};
        end else if (st_r == bridge_pkg::ST_WAIT && eng_done && is_spi && ph_r != bridge_pkg::PH_DATA) begin
            // R15: spi header bytes return the captured input
            pkt_r[(ph_r == bridge_pkg::PH_ADDR) ? 6'h01 : 6'h03] <= eng_rx;
        end else if (st_r == bridge_pkg::ST_WAIT && eng_done && (rd_phase || (is_spi && !is_wr))) begin
            // R17: read data lands from byte 4
            pkt_r[data_slot(di_r)] <= eng_rx;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= bridge_pkg::ST_IDLE;
            ph_r <= bridge_pkg::PH_START;
            rsp_r <= '0;
            count_r <= 7'h00;
            total_r <= 7'h00;
            di_r <= 6'h00;
            ridx_r <= 6'h00;
            stat_r <= 8'h00;
            fail_r <= 1'b0;
            cs_n_r <= 1'b1;
            rdy_r <= 1'b0;
            eng_start_r <= 1'b0;
            gpio_r <= 7'h7F;
        end else begin
            eng_start_r <= 1'b0;
            case (st_r)
                // R19: nothing accepted until the previous reply is gone
                bridge_pkg::ST_IDLE: begin
                    if (setup_hit) begin
                        st_r <= bridge_pkg::ST_RECV;
                        rdy_r <= 1'b1;
                        count_r <= 7'h00;
                    end
                end
                bridge_pkg::ST_RECV: begin
                    if (i_cmd.valid) begin
                        if (count_r < bridge_pkg::PACKET_BYTES) count_r <= count_r + 7'h01;
                        if (i_cmd.last) begin
                            rdy_r <= 1'b0;
                            st_r <= bridge_pkg::ST_DECODE;
                        end
                    end
                end
                bridge_pkg::ST_DECODE: begin
                    fail_r <= 1'b0;
                    di_r <= 6'h00;
                    ridx_r <= 6'h00;
                    if (req_err) begin
                        // R14: reject, echo what was sent
                        stat_r <= bridge_pkg::REQUEST_ERROR_FLAG;
                        total_r <= count_r;
                        st_r <= bridge_pkg::ST_REPLY;
                    end else if (is_gpio) begin
                        // R18: seven pins on bits 6..0
                        if (is_wr) gpio_r <= pkt_r[4][6:0];
                        stat_r <= bridge_pkg::REQUEST_DONE_FLAG;
                        total_r <= bridge_pkg::HDR_BYTES + 7'h01;
                        st_r <= bridge_pkg::ST_REPLY;
                    end else begin
                        // R16: reply carries header plus length bytes
                        total_r <= bridge_pkg::HDR_BYTES + len[6:0];
                        ph_r <= is_i2c ? bridge_pkg::PH_START
                            : (iface == bridge_pkg::SPI_WORD_ADDR_SELECT) ? bridge_pkg::PH_ADDR : bridge_pkg::PH_REG;
                        cs_n_r <= is_i2c;
                        st_r <= bridge_pkg::ST_EXEC;
                    end
                end
                bridge_pkg::ST_EXEC: begin
                    eng_start_r <= 1'b1;
                    st_r <= bridge_pkg::ST_WAIT;
                end
                bridge_pkg::ST_WAIT: begin
                    if (eng_done) begin
                        st_r <= bridge_pkg::ST_EXEC;
                        if (nack_hit) begin
                            // R13: abandon with a stop
                            fail_r <= 1'b1;
                            ph_r <= bridge_pkg::PH_STOP;
                        end else begin
                            case (ph_r)
                                bridge_pkg::PH_START: ph_r <= bridge_pkg::PH_ADDR;
                                bridge_pkg::PH_ADDR: ph_r <= bridge_pkg::PH_REG;
                                bridge_pkg::PH_RSTART: ph_r <= bridge_pkg::PH_RADDR;
                                bridge_pkg::PH_RADDR: ph_r <= bridge_pkg::PH_RDATA;
                                bridge_pkg::PH_STOP: begin
                                    // R12: done flag only on clean completion
                                    stat_r <= fail_r ? bridge_pkg::BUS_FAILURE_FLAG : bridge_pkg::REQUEST_DONE_FLAG;
                                    st_r <= bridge_pkg::ST_REPLY;
                                end
                                default: begin
                                    if ((ph_r == bridge_pkg::PH_REG && len == 8'h00)
                                        || (ph_r != bridge_pkg::PH_REG && last_data)) begin
                                        if (is_i2c) begin
                                            ph_r <= bridge_pkg::PH_STOP;
                                        end else begin
                                            cs_n_r <= 1'b1;
                                            stat_r <= bridge_pkg::REQUEST_DONE_FLAG;
                                            st_r <= bridge_pkg::ST_REPLY;
                                        end
                                    end else if (ph_r == bridge_pkg::PH_REG) begin
                                        ph_r <= (is_i2c && !is_wr) ? bridge_pkg::PH_RSTART : bridge_pkg::PH_DATA;
                                    end else begin
                                        di_r <= di_r + 6'h01;
                                    end
                                end
                            endcase
                        end
                    end
                end
                bridge_pkg::ST_REPLY: begin
                    // R10: reply packet after every command
                    if (!rsp_r.valid || i_rsp_ready) begin
                        if (rsp_r.valid && rsp_r.last) begin
                            rsp_r.valid <= 1'b0;
                            st_r <= bridge_pkg::ST_IDLE;
                        end else begin
                            rsp_r <= '{valid: 1'b1, data: rsp_byte, last: rsp_last};
                            ridx_r <= ridx_r + 6'h01;
                        end
                    end
                end
                default: st_r <= bridge_pkg::ST_IDLE;
            endcase
        end
    end

    assign o_cmd_ready = rdy_r;
    assign o_rsp = rsp_r;
    assign o_scl_out = 1'b0;
    assign o_sda_out = 1'b0;
    assign o_spi_cs_n = cs_n_r;
    assign o_gpio = gpio_r;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);

    property p_hdr_echo;
        o_rsp.valid && ridx_r == 6'h01 |-> o_rsp.data[4:0] == pkt_r[0][4:0];
    endproperty
    a_hdr_echo: assert property (p_hdr_echo) else $error("reply byte 0 lost the header"); // R11

    property p_done_only;
        o_rsp.valid && ridx_r == 6'h01 && !fail_r && !req_err |-> o_rsp.data == (pkt_r[0] | 8'h20);
    endproperty
    a_done_only: assert property (p_done_only) else $error("clean reply byte 0 wrong"); // R12

    property p_bus_fail;
        o_rsp.valid && ridx_r == 6'h01 && fail_r && !req_err |-> o_rsp.data[6] && !o_rsp.data[5];
    endproperty
    a_bus_fail: assert property (p_bus_fail) else $error("bus failure flag missing"); // R13

    property p_nack_stop;
        st_r == bridge_pkg::ST_WAIT && eng_done && nack_hit |=> fail_r && ph_r == bridge_pkg::PH_STOP;
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("missing acknowledge not handled"); // R13

    property p_req_err;
        o_rsp.valid && ridx_r == 6'h01 && req_err |-> o_rsp.data[7] && !o_rsp.data[5];
    endproperty
    a_req_err: assert property (p_req_err) else $error("request error flag missing"); // R14

    property p_len_echo;
        o_rsp.valid && ridx_r == 6'h03 |-> o_rsp.data == pkt_r[2];
    endproperty
    a_len_echo: assert property (p_len_echo) else $error("length not echoed"); // R16

    property p_spi_cs;
        $rose(o_sclk) |-> !o_spi_cs_n && is_spi;
    endproperty
    a_spi_cs: assert property (p_spi_cs) else $error("spi clock without select"); // R15

    property p_reply_start;
        $rose(st_r == bridge_pkg::ST_REPLY) |-> ##1 o_rsp.valid && ridx_r == 6'h01;
    endproperty
    a_reply_start: assert property (p_reply_start) else $error("reply did not start"); // R10

    property p_one_cmd;
        o_rsp.valid |-> !o_cmd_ready && st_r == bridge_pkg::ST_REPLY;
    endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("command taken during reply"); // R19

    property p_gpio_write;
        st_r == bridge_pkg::ST_DECODE && !req_err && is_gpio && is_wr |=> o_gpio == $past(pkt_r[4][6:0]);
    endproperty
    a_gpio_write: assert property (p_gpio_write) else $error("pin write not applied"); // R18
endmodule // usb_serial_bus_command_bridge

/* tb/host_model.sv */
// Purpose: host side of the command bridge, sends commands and takes replies
// Assumes: reply sink may stall every other cycle
// Notes: signals change 1 ns after the rising edge
`timescale 1ns/1ps
module host_model (
    input wire logic i_clock,
    input wire logic i_cmd_ready,
    input wire bridge_pkg::byte_s i_rsp,
    output bridge_pkg::setup_s o_setup,
    output bridge_pkg::byte_s o_cmd,
    output logic o_rsp_ready
);
    initial begin
        o_setup = '0;
        o_cmd = '0;
        o_rsp_ready = 1'b0;
    end
    task automatic send(input logic [7:0] b[$]);
        logic rdy;
        @(posedge i_clock) #1 o_setup = {1'b1, 8'h21, 8'h09, 16'h0003};
        foreach (b[i]) begin
            o_cmd = {1'b1, b[i], i == b.size() - 1};
            do begin
                rdy = i_cmd_ready;
                @(posedge i_clock) #1 o_setup = '0;
            end while (rdy !== 1'b1);
        end
        o_cmd = '0;
    endtask
    task automatic recv(output logic [7:0] r[$], input logic slow);
        logic v;
        logic l;
        logic [7:0] d;
        r = {};
        for (int n = 0; n < 20000; n++) begin
            o_rsp_ready = !slow || n[0];
            v = i_rsp.valid & o_rsp_ready;
            d = i_rsp.data;
            l = i_rsp.last;
            @(posedge i_clock) #1;
            if (v === 1'b1) begin
                r.push_back(d);
                if (l === 1'b1) break;
            end
        end
        o_rsp_ready = 1'b0;
    endtask
endmodule // host_model

/* tb/usb_serial_bus_command_bridge_test.sv */
// Purpose: self-checking bench for the command bridge
// Assumes: no two-wire target present, so the data line floats high
// Notes: spi input is the inverted spi output, so captured bytes come back inverted
`timescale 1ns/1ps
module usb_serial_bus_command_bridge_test;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    bridge_pkg::setup_s setup;
    bridge_pkg::byte_s cmd;
    bridge_pkg::byte_s rsp;
    logic cmd_ready, rsp_ready, sda_oe, cs_n, mosi;
    logic [6:0] gpio_o;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #20 clock = ~clock;
    host_model h (.i_clock(clock), .i_cmd_ready(cmd_ready), .i_rsp(rsp), .o_setup(setup), .o_cmd(cmd),
        .o_rsp_ready(rsp_ready));
    usb_serial_bus_command_bridge DUT (.i_clock(clock), .i_arst_n(arst_n), .i_setup(setup), .i_cmd(cmd),
        .o_cmd_ready(cmd_ready), .o_rsp(rsp), .i_rsp_ready(rsp_ready), .i_sda(~sda_oe), .o_scl_oe(),
        .o_scl_out(), .o_sda_oe(sda_oe), .o_sda_out(), .o_sclk(), .o_mosi(mosi), .i_miso(~mosi),
        .o_spi_cs_n(cs_n), .o_gpio(gpio_o), .i_gpio(7'h2A));
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic run(input logic [7:0] c[$], input logic [7:0] e[$], input logic slow);
        logic [7:0] r[$];
        h.send(c);
        h.recv(r, slow);
        check("reply length", 8'(e.size()), 8'(r.size()));
        foreach (e[i]) check("reply byte", e[i], i < r.size() ? r[i] : 8'hXX);
    endtask
    task automatic t_gpio;
        run('{8'h18, 8'h00, 8'h01, 8'h00, 8'h3F}, '{8'h38, 8'h00, 8'h01, 8'h00, 8'h3F}, 1'b0);
        check("gpio pins", 8'h3F, {1'b0, gpio_o});
        run('{8'h08, 8'h00, 8'h01, 8'h00}, '{8'h28, 8'h00, 8'h01, 8'h00, 8'h2A}, 1'b1);
        $display("test gpio done");
    endtask
    task automatic t_bad;
        run('{8'h13, 8'h80, 8'h02, 8'h01, 8'h45, 8'hA0}, '{8'h93, 8'h80, 8'h02, 8'h01, 8'h45, 8'hA0}, 1'b0);
        $display("test malformed done");
    endtask
    task automatic t_nack;
        run('{8'h12, 8'h80, 8'h02, 8'h01, 8'h45, 8'hA0}, '{8'h52, 8'h80, 8'h02, 8'h01, 8'h45, 8'hA0}, 1'b0);
        run('{8'h11, 8'h80, 8'h02, 8'h01, 8'h45, 8'hA0}, '{8'h51, 8'h80, 8'h02, 8'h01, 8'h45, 8'hA0}, 1'b1);
        run('{8'h02, 8'hA0, 8'h00, 8'h01}, '{8'h42, 8'hA0, 8'h00, 8'h01}, 1'b0);
        $display("test nack done");
    endtask
    task automatic t_spi;
        run('{8'h14, 8'h12, 8'h01, 8'h34, 8'hAA}, '{8'h34, 8'hED, 8'h01, 8'hCB, 8'hAA}, 1'b1);
        run('{8'h00, 8'h00, 8'h02, 8'h56}, '{8'h20, 8'h00, 8'h02, 8'hA9, 8'hFF, 8'hFF}, 1'b0);
        check("spi select idle", 8'h01, {7'h00, cs_n});
        $display("test spi done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // bounded run: any hang ends in the report
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        #1 arst_n = 1'b1;
        t_gpio();
        t_bad();
        t_nack();
        t_spi();
        wrap_up();
    end
endmodule // usb_serial_bus_command_bridge_test
